// File: design/fsp_defines.svh
// Constants for the flash status and protection logic: opcodes, bit
// positions, write masks, reset values and array unit sizes.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// Instruction codes
`define FSP_OP_WREN 8'h06
`define FSP_OP_WRDI 8'h04
`define FSP_OP_WRSR1 8'h01
`define FSP_OP_WRSR2 8'h31
`define FSP_OP_WRSR3 8'h11
`define FSP_OP_RDSR1 8'h05
`define FSP_OP_RDSR2 8'h35
`define FSP_OP_RDSR3 8'h15
`define FSP_OP_PROG 8'h02
`define FSP_OP_SECT_ERASE 8'h20
`define FSP_OP_BLK_ERASE 8'hD8
`define FSP_OP_CHIP_ERASE 8'hC7
`define FSP_OP_CHIP_ERASE2 8'h60
`define FSP_OP_SUSPEND 8'h75
`define FSP_OP_RESUME 8'h7A
`define FSP_OP_PREFIX1 8'hAA
`define FSP_OP_PREFIX2 8'h55

// Word one field positions
`define FSP_WEL_BIT 1
`define FSP_BP_LSB 2
`define FSP_TB_BIT 5
`define FSP_SEC_BIT 6
`define FSP_SRP_BIT 7
// Word two field positions
`define FSP_SRL_BIT 0
`define FSP_QE_BIT 1
`define FSP_LB_LSB 3
`define FSP_CMP_BIT 6
`define FSP_SUS_BIT 7
// Word three field positions
`define FSP_WPS_BIT 2
`define FSP_DRV_LSB 5

// Writable bits of each word; everything else is reserved or read-only
`define FSP_SR1_WMASK 8'hFC
`define FSP_SR2_WMASK 8'h7B
`define FSP_SR3_WMASK 8'h64
`define FSP_LB_MASK 8'h38

// Reset values
`define FSP_SR1_RESET 8'h00
`define FSP_SR2_RESET 8'h00
`define FSP_SR3_RESET 8'h60

// Array unit sizes in bytes
`define FSP_PAGE_BYTES 32'h0000_0100
`define FSP_SECTOR_BYTES 32'h0000_1000
`define FSP_BLOCK_BYTES 32'h0001_0000

`endif

// File: design/fsp_pkg.sv
// Types shared by the flash status and protection logic.
// Assumes nothing of its surroundings.
package fsp_pkg;

  // Prefix tracker for the permanent lock sequence, Gray along the path
  typedef enum logic [1:0] {
    FSP_PFX_IDLE = 2'b00,
    FSP_PFX_SAW_FIRST = 2'b01,
    FSP_PFX_ARMED = 2'b11
  } fsp_prefix_type;

endpackage

// File: design/fsp_range_check.sv
// Protected-region decoder: turns the protect fields into one address
// window and tests an operation span against it.
// Assumes op_lo <= op_hi, both inside the array.
`timescale 1ns/1ps
`include "fsp_defines.svh"

module fsp_range_check #(
  parameter int ADDR_W = 22
) (
  input wire logic cmp,
  input wire logic sec,
  input wire logic tb,
  input wire logic [2:0] bp,
  input wire logic [ADDR_W-1:0] op_lo,
  input wire logic [ADDR_W-1:0] op_hi,
  output logic prot
);
  import fsp_pkg::*;

  localparam logic [ADDR_W:0] TOTAL = (ADDR_W+1)'(1) << ADDR_W;

  if (ADDR_W < 16 || ADDR_W > 30) begin : g_bad_width
    $error("fsp_range_check: ADDR_W out of range");
  end

  // Size of the base region; block units or sector units
  function automatic logic [ADDR_W:0] region_size(input logic s, input logic [2:0] b);
    logic [ADDR_W:0] unit;
    unit = s ? (ADDR_W+1)'(`FSP_SECTOR_BYTES) : (ADDR_W+1)'(`FSP_BLOCK_BYTES);
    if (b == 3'h0) begin
      region_size = '0;
    end else if (b == 3'h7) begin
      region_size = TOTAL;
    end else if (s && b[2]) begin
      region_size = unit << 3;
    end else begin
      region_size = unit << (b - 3'h1);
    end
  endfunction

  logic [ADDR_W:0] size_w;
  logic [ADDR_W:0] base_lo;
  logic [ADDR_W:0] base_hi;
  logic [ADDR_W:0] lo_w;
  logic [ADDR_W:0] hi_w;
  logic empty_w;
  logic overlap_w;
  logic inside_w;

  // Top end when tb is low, bottom end otherwise
  assign size_w = region_size(sec, bp);
  assign empty_w = (size_w == '0);
  assign base_lo = tb ? '0 : TOTAL - size_w;
  assign base_hi = tb ? size_w - (ADDR_W+1)'(1) : TOTAL - (ADDR_W+1)'(1);
  assign lo_w = {1'b0, op_lo};
  assign hi_w = {1'b0, op_hi};
  assign overlap_w = !empty_w && (lo_w <= base_hi) && (hi_w >= base_lo);
  assign inside_w = !empty_w && (lo_w >= base_lo) && (hi_w <= base_hi);
  // Complement makes the base region the only writable part
  assign prot = cmp ? !inside_w : overlap_w;

endmodule // fsp_range_check

// File: design/fsp_status_protect.sv
// Status and configuration word protection for a serial flash: serial
// front end, three status words, write gating and array-op screening.
// Assumes serial pins arrive asynchronously and sclk is much slower
// than clk_sys (at least eight system clocks per serial period).
`timescale 1ns/1ps
`include "fsp_defines.svh"

module fsp_status_protect #(
  parameter int ADDR_W = 22,
  parameter bit QE_DEFAULT = 1'b0
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic mosi_pin,
  input wire logic wp_n_pin,
  output logic miso_o,
  output logic miso_oe_n,
  output logic [23:0] status_word_o,
  output logic hold_en_o,
  output logic quad_io_en_o,
  output logic [1:0] drive_strength_o,
  output logic [6:0] drive_pct_o,
  output logic [2:0] sec_reg_ro_o,
  output logic prog_go_o,
  output logic erase_go_o,
  output logic [ADDR_W-1:0] op_lo_o,
  output logic [ADDR_W-1:0] op_hi_o,
  output logic op_ignored_o,
  output logic sr_refused_o
);
  import fsp_pkg::*;

  if (ADDR_W < 16 || ADDR_W > 24) begin : g_bad_width
    $error("fsp_status_protect: ADDR_W must be 16 to 24");
  end

  // Drive field to percent of full strength
  function automatic logic [6:0] drive_pct(input logic [1:0] f);
    unique case (f)
      2'b00: drive_pct = 7'h64;
      2'b01: drive_pct = 7'h4B;
      2'b10: drive_pct = 7'h32;
      2'b11: drive_pct = 7'h19;
    endcase
  endfunction

  // Two-stage synchronisers; stage 0 is read only by stage 1
  logic [1:0] cs_sync_reg;
  logic [1:0] sclk_sync_reg;
  logic [1:0] mosi_sync_reg;
  logic [1:0] wp_sync_reg;
  logic cs_prev_reg;
  logic sclk_prev_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cs_sync_reg <= 2'h3;
      sclk_sync_reg <= 2'h0;
      mosi_sync_reg <= 2'h0;
      wp_sync_reg <= 2'h3;
      cs_prev_reg <= 1'b1;
      sclk_prev_reg <= 1'b0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], cs_n_pin};
      sclk_sync_reg <= {sclk_sync_reg[0], sclk_pin};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_pin};
      wp_sync_reg <= {wp_sync_reg[0], wp_n_pin};
      cs_prev_reg <= cs_sync_reg[1];
      sclk_prev_reg <= sclk_sync_reg[1];
    end
  end

  // Edge and frame decode on the synchronised copies
  wire in_frame = ~cs_sync_reg[1];
  wire frame_end = cs_sync_reg[1] & ~cs_prev_reg;
  wire sclk_rise = in_frame & sclk_sync_reg[1] & ~sclk_prev_reg;
  wire sclk_fall = in_frame & ~sclk_sync_reg[1] & sclk_prev_reg;

  // Byte assembly, MSB first on rising serial clock
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] opcode_reg;
  logic [7:0] data1_reg;
  logic [7:0] data2_reg;
  logic [23:0] addr_reg;
  wire [7:0] shift_next = {shift_reg[6:0], mosi_sync_reg[1]};
  wire byte_done = sclk_rise & (bit_cnt_reg == 3'h7);

  always_ff @(posedge clk_sys) begin
    if (srst || !in_frame) begin
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
    end else if (sclk_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg <= shift_next;
      if (byte_done && byte_cnt_reg != 3'h7) begin
        byte_cnt_reg <= byte_cnt_reg + 3'h1;
      end
    end
  end

  // Captured fields; only meaningful once the matching byte arrived
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      opcode_reg <= 8'h00;
      data1_reg <= 8'h00;
      data2_reg <= 8'h00;
      addr_reg <= 24'h000000;
    end else if (byte_done) begin
      if (byte_cnt_reg == 3'h0) opcode_reg <= shift_next;
      if (byte_cnt_reg == 3'h1) data1_reg <= shift_next;
      if (byte_cnt_reg == 3'h2) data2_reg <= shift_next;
      if (byte_cnt_reg >= 3'h1 && byte_cnt_reg <= 3'h3) begin
        addr_reg <= {addr_reg[15:0], shift_next};
      end
    end
  end

  // State registers
  logic [7:0] sr1_reg;
  logic [7:0] sr2_reg;
  logic [7:0] sr3_reg;
  logic wel_reg;
  logic sus_reg;
  logic otp_reg;
  logic ind_locked_reg;
  fsp_prefix_type pfx_reg;
  fsp_prefix_type pfx_next;

  // Instructions commit only on a whole-byte frame end
  wire commit = frame_end & (bit_cnt_reg == 3'h0) & (byte_cnt_reg != 3'h0);
  wire op_is_wren = commit & (opcode_reg == `FSP_OP_WREN) & (byte_cnt_reg == 3'h1);
  wire op_is_wrdi = commit & (opcode_reg == `FSP_OP_WRDI) & (byte_cnt_reg == 3'h1);
  wire op_is_susp = commit & (opcode_reg == `FSP_OP_SUSPEND) & (byte_cnt_reg == 3'h1);
  wire op_is_resm = commit & (opcode_reg == `FSP_OP_RESUME) & (byte_cnt_reg == 3'h1);
  wire wr1 = commit & (opcode_reg == `FSP_OP_WRSR1) & (byte_cnt_reg >= 3'h2);
  wire wr2_via1 = wr1 & (byte_cnt_reg >= 3'h3);
  wire wr2 = wr2_via1 | (commit & (opcode_reg == `FSP_OP_WRSR2) & (byte_cnt_reg == 3'h2));
  wire wr3 = commit & (opcode_reg == `FSP_OP_WRSR3) & (byte_cnt_reg == 3'h2);
  wire sr_write = wr1 | wr2 | wr3;

  // Status write gating, sampled at the completing frame edge
  wire status_lock_bit = sr2_reg[`FSP_SRL_BIT];
  wire status_protect_bit = sr1_reg[`FSP_SRP_BIT];
  wire qe = sr2_reg[`FSP_QE_BIT];
  wire wp_counts = ~qe;
  wire wp_low = ~wp_sync_reg[1];
  wire hw_block = status_protect_bit & wp_counts & wp_low;
  wire sr_gate_open = wel_reg & ~otp_reg & ~status_lock_bit & ~hw_block;
  wire sr_write_ok = sr_write & sr_gate_open;

  // New word values; reserved and read-only bits keep their state
  wire [7:0] sr2_src = wr2_via1 ? data2_reg : data1_reg;
  wire [7:0] sr1_new = (sr1_reg & ~`FSP_SR1_WMASK) | (data1_reg & `FSP_SR1_WMASK);
  wire [7:0] sr2_new = (sr2_reg & ~`FSP_SR2_WMASK) | (sr2_src & `FSP_SR2_WMASK)
                       | (sr2_reg & `FSP_LB_MASK);
  wire [7:0] sr3_new = (sr3_reg & ~`FSP_SR3_WMASK) | (data1_reg & `FSP_SR3_WMASK);
  wire otp_set = sr_write_ok & wr2 & (pfx_reg == FSP_PFX_ARMED) & sr2_src[`FSP_SRL_BIT];

  // Array operation span: address with low bits masked per unit
  wire is_pp = commit & (opcode_reg == `FSP_OP_PROG) & (byte_cnt_reg >= 3'h5);
  wire is_se = commit & (opcode_reg == `FSP_OP_SECT_ERASE) & (byte_cnt_reg == 3'h4);
  wire is_be = commit & (opcode_reg == `FSP_OP_BLK_ERASE) & (byte_cnt_reg == 3'h4);
  wire is_ce = commit & ((opcode_reg == `FSP_OP_CHIP_ERASE) | (opcode_reg == `FSP_OP_CHIP_ERASE2))
               & (byte_cnt_reg == 3'h1);
  wire array_req = is_pp | is_se | is_be | is_ce;
  wire [ADDR_W-1:0] span_mask = is_ce ? {ADDR_W{1'b1}}
                              : is_be ? ADDR_W'(`FSP_BLOCK_BYTES - 32'h1)
                              : is_se ? ADDR_W'(`FSP_SECTOR_BYTES - 32'h1)
                              : ADDR_W'(`FSP_PAGE_BYTES - 32'h1);
  wire [ADDR_W-1:0] span_lo = addr_reg[ADDR_W-1:0] & ~span_mask;
  wire [ADDR_W-1:0] span_hi = addr_reg[ADDR_W-1:0] | span_mask;
  logic range_prot;

  fsp_range_check #(.ADDR_W(ADDR_W)) u_range (
    .cmp(sr2_reg[`FSP_CMP_BIT]),
    .sec(sr1_reg[`FSP_SEC_BIT]),
    .tb(sr1_reg[`FSP_TB_BIT]),
    .bp(sr1_reg[`FSP_BP_LSB +: 3]),
    .op_lo(span_lo),
    .op_hi(span_hi),
    .prot(range_prot)
  );

  // Scheme select chooses field decode or the individual locks
  wire protect_scheme_select = sr3_reg[`FSP_WPS_BIT];
  wire prot_hit = protect_scheme_select ? ind_locked_reg : range_prot;
  wire array_ok = array_req & wel_reg & ~prot_hit;

  // Status words and flags
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sr1_reg <= `FSP_SR1_RESET;
      sr2_reg <= `FSP_SR2_RESET | (8'(QE_DEFAULT) << `FSP_QE_BIT);
      sr3_reg <= `FSP_SR3_RESET;
      otp_reg <= 1'b0;
      ind_locked_reg <= 1'b1;
    end else begin
      if (sr_write_ok && wr1) sr1_reg <= sr1_new;
      if (sr_write_ok && wr2) sr2_reg <= sr2_new;
      if (sr_write_ok && wr3) sr3_reg <= sr3_new;
      if (otp_set) otp_reg <= 1'b1;
    end
  end

  // Write-enable latch and pause flag; a power cycle clears both
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wel_reg <= 1'b0;
      sus_reg <= 1'b0;
    end else begin
      if (op_is_wren) begin
        wel_reg <= 1'b1;
      end else if (op_is_wrdi || array_ok || sr_write_ok) begin
        wel_reg <= 1'b0;
      end
      if (op_is_susp) begin
        sus_reg <= 1'b1;
      end else if (op_is_resm) begin
        sus_reg <= 1'b0;
      end
    end
  end

  // Prefix tracker: two prefix frames arm a status write only in the very next frame
  always_comb begin
    pfx_next = FSP_PFX_IDLE;
    if (commit && opcode_reg == `FSP_OP_PREFIX1 && byte_cnt_reg == 3'h1) begin
      pfx_next = FSP_PFX_SAW_FIRST;
    end else if (commit && opcode_reg == `FSP_OP_PREFIX2 && byte_cnt_reg == 3'h1
                 && pfx_reg == FSP_PFX_SAW_FIRST) begin
      pfx_next = FSP_PFX_ARMED;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) pfx_reg <= FSP_PFX_IDLE;
    else if (frame_end) pfx_reg <= pfx_next;
  end

  // Readable words; reserved bits read as zero
  wire [7:0] sr1_rd = {sr1_reg[7:2], wel_reg, 1'b0};
  wire [7:0] sr2_rd = {sus_reg, sr2_reg[6:3], 1'b0, sr2_reg[1:0]};
  wire [7:0] sr3_rd = sr3_reg & `FSP_SR3_WMASK;

  // Read-status shifter: loads after opcode, shifts on falling sclk
  logic [7:0] out_shift_reg;
  logic out_active_reg;
  logic miso_reg;
  wire [7:0] rd_sel = (shift_next == `FSP_OP_RDSR1) ? sr1_rd
                    : (shift_next == `FSP_OP_RDSR2) ? sr2_rd : sr3_rd;
  wire rd_hit = (shift_next == `FSP_OP_RDSR1) | (shift_next == `FSP_OP_RDSR2)
                | (shift_next == `FSP_OP_RDSR3);

  always_ff @(posedge clk_sys) begin
    if (srst || !in_frame) begin
      out_shift_reg <= 8'h00;
      out_active_reg <= 1'b0;
      miso_reg <= 1'b0;
    end else if (byte_done && byte_cnt_reg == 3'h0 && rd_hit) begin
      out_shift_reg <= rd_sel;
      out_active_reg <= 1'b1;
    end else if (sclk_fall && out_active_reg) begin
      miso_reg <= out_shift_reg[7];
      out_shift_reg <= {out_shift_reg[6:0], out_shift_reg[7]}; // Repeats the word
    end
  end

  // Registered result outputs; pulses last one cycle
  logic prog_go_reg;
  logic erase_go_reg;
  logic ignored_reg;
  logic refused_reg;
  logic [ADDR_W-1:0] op_lo_reg;
  logic [ADDR_W-1:0] op_hi_reg;
  logic [23:0] status_word_reg;
  logic [6:0] drive_pct_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prog_go_reg <= 1'b0;
      erase_go_reg <= 1'b0;
      ignored_reg <= 1'b0;
      refused_reg <= 1'b0;
      op_lo_reg <= '0;
      op_hi_reg <= '0;
      status_word_reg <= 24'h000000;
      drive_pct_reg <= 7'h19;
    end else begin
      prog_go_reg <= array_ok & is_pp;
      erase_go_reg <= array_ok & ~is_pp;
      ignored_reg <= array_req & ~array_ok;
      refused_reg <= sr_write & ~sr_gate_open;
      if (array_ok) begin
        op_lo_reg <= span_lo;
        op_hi_reg <= span_hi;
      end
      status_word_reg <= {sr3_rd, sr2_rd, sr1_rd};
      drive_pct_reg <= drive_pct(sr3_reg[`FSP_DRV_LSB +: 2]);
    end
  end

  assign miso_o = miso_reg;
  assign miso_oe_n = ~(out_active_reg & in_frame);
  assign status_word_o = status_word_reg;
  assign hold_en_o = ~qe;
  assign quad_io_en_o = qe;
  assign drive_strength_o = sr3_reg[`FSP_DRV_LSB +: 2];
  assign drive_pct_o = drive_pct_reg;
  assign sec_reg_ro_o = sr2_reg[`FSP_LB_LSB +: 3];
  assign prog_go_o = prog_go_reg;
  assign erase_go_o = erase_go_reg;
  assign op_lo_o = op_lo_reg;
  assign op_hi_o = op_hi_reg;
  assign op_ignored_o = ignored_reg;
  assign sr_refused_o = refused_reg;

  // Checks on the gating, flags and array screening
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  srl_blocks_a: assert property (sr_write && status_lock_bit |=>
    $stable(sr1_reg) && $stable(sr2_reg) && $stable(sr3_reg) && refused_reg)
    else $error("status write taken while lock bit set");
  hw_protect_a: assert property (sr_write && !status_lock_bit && status_protect_bit && !qe && wp_low |=>
    refused_reg && $stable(sr1_reg) && $stable(sr3_reg))
    else $error("status write taken with protect pin low");
  wp_quad_a: assert property (sr_write && wel_reg && !status_lock_bit && !otp_reg && qe |=>
    !refused_reg && !wel_reg)
    else $error("protect pin gated a quad-mode status write");
  sw_write_a: assert property (sr_write && wel_reg && !status_lock_bit && !status_protect_bit && !otp_reg |=>
    !wel_reg && !refused_reg)
    else $error("unprotected status write not accepted");
  otp_lock_a: assert property (otp_reg && sr_write |=> refused_reg)
    else $error("status write accepted after permanent lock");
  wel_set_a: assert property (op_is_wren |=> wel_reg ##1 wel_reg)
    else $error("write enable did not set latch");
  pause_flag_a: assert property (op_is_susp |=> status_word_reg[8+`FSP_SUS_BIT] == 1'b0
    ##1 status_word_reg[8+`FSP_SUS_BIT])
    else $error("pause flag not shown after suspend");
  lb_sticky_a: assert property ($past(sec_reg_ro_o) == (sec_reg_ro_o & $past(sec_reg_ro_o)))
    else $error("security lock bit cleared");
  drive_map_a: assert property (##1 drive_pct_reg == drive_pct($past(drive_strength_o)))
    else $error("drive strength decode wrong");
  prot_ignore_a: assert property (array_req && prot_hit |=>
    ignored_reg && !prog_go_reg && !erase_go_reg)
    else $error("protected array operation not ignored");
  locks_set_a: assert property (array_req && protect_scheme_select |=> ignored_reg)
    else $error("individual locks did not protect array");

  sr_write_c: cover property (sr_write_ok ##1 !wel_reg);
  hw_refuse_c: cover property (sr_write && hw_block);
  otp_arm_c: cover property (otp_set);
  prog_go_c: cover property (prog_go_reg);

endmodule // fsp_status_protect

// File: dv/fsp_spi_host.sv
// Behavioural serial host that frames instructions for the status logic.
// Assumes clk_sys is the device system clock; one serial half period
// spans four system clocks, so the serial clock runs at 320 ns.
`timescale 1ns/1ps

module fsp_spi_host (
  input wire logic clk_sys,
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic mosi_pin,
  input wire logic miso_o,
  input wire logic miso_oe_n
);
  logic [7:0] rd_byte;

  // Serial clock stands low between frames
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    mosi_pin = 1'b0;
    rd_byte = 8'h00;
  end

  // Half a serial period, launched just after a system edge
  task automatic half();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  // Whole bytes only, taken from the top of data, MSB first
  task automatic frame(input int n, input logic [39:0] data);
    logic [39:0] sh;
    sh = data;
    @(posedge clk_sys);
    #1;
    cs_n_pin = 1'b0;
    for (int i = 0; i < 8 * n; i++) begin
      mosi_pin = sh[39];
      sh = sh << 1;
      half();
      sclk_pin = 1'b1;
      rd_byte = {rd_byte[6:0], miso_o}; // Last byte read stays here
      half();
      sclk_pin = 1'b0;
    end
    half();
    cs_n_pin = 1'b1;
    mosi_pin = ~mosi_pin; // Released line must not echo the last bit
    // Gap covers commit plus status view lag
    repeat (10) @(posedge clk_sys);
    #1;
  endtask
endmodule // fsp_spi_host

// File: dv/fsp_status_protect_tb.sv
// Self-checking bench for the flash status and protection logic.
// Assumes the host model fsp_spi_host and the shared design constants.
`timescale 1ns/1ps
`include "fsp_defines.svh"

module fsp_status_protect_tb;
  logic clk_sys, srst, wp_n_pin, cs_n_pin, sclk_pin, mosi_pin, miso_o, miso_oe_n;
  logic hold_en_o, quad_io_en_o, prog_go_o, erase_go_o, op_ignored_o, sr_refused_o;
  logic [23:0] status_word_o;
  logic [1:0] drive_strength_o;
  logic [6:0] drive_pct_o;
  logic [2:0] sec_reg_ro_o;
  logic [21:0] op_lo_o, op_hi_o;
  logic [6:0] pct [4] = '{7'h64, 7'h4B, 7'h32, 7'h19};
  int mismatches = 0;
  int checked = 0;
  int n_ref, n_ign, n_erase, n_prog;

  fsp_status_protect #(.ADDR_W(22), .QE_DEFAULT(1'b0)) i_fsp_status_protect (
    .clk_sys(clk_sys), .srst(srst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .mosi_pin(mosi_pin), .wp_n_pin(wp_n_pin), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
    .status_word_o(status_word_o), .hold_en_o(hold_en_o), .quad_io_en_o(quad_io_en_o),
    .drive_strength_o(drive_strength_o), .drive_pct_o(drive_pct_o),
    .sec_reg_ro_o(sec_reg_ro_o), .prog_go_o(prog_go_o), .erase_go_o(erase_go_o),
    .op_lo_o(op_lo_o), .op_hi_o(op_hi_o), .op_ignored_o(op_ignored_o),
    .sr_refused_o(sr_refused_o));

  fsp_spi_host i_fsp_spi_host (.clk_sys(clk_sys), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .mosi_pin(mosi_pin), .miso_o(miso_o), .miso_oe_n(miso_oe_n));

  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Pulses stand one cycle, so tally them at every edge
  always @(posedge clk_sys) begin
    n_ref <= n_ref + int'(sr_refused_o === 1'b1);
    n_ign <= n_ign + int'(op_ignored_o === 1'b1);
    n_erase <= n_erase + int'(erase_go_o === 1'b1);
    n_prog <= n_prog + int'(prog_go_o === 1'b1);
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Compare refusal, ignore and erase tallies, then start them afresh
  task automatic pulses(input int r, input int i, input int e);
    check(24'(n_ref), 24'(r));
    check(24'(n_ign), 24'(i));
    check(24'(n_erase), 24'(e));
    n_ref = 0;
    n_ign = 0;
    n_erase = 0;
  endtask

  task automatic send(input int n, input logic [39:0] d);
    i_fsp_spi_host.frame(n, d);
  endtask

  // Enable then one-byte status write
  task automatic wr(input logic [7:0] op, input logic [7:0] v);
    send(1, {`FSP_OP_WREN, 32'h0});
    send(2, {op, v, 24'h0});
  endtask

  task automatic erase(input logic [23:0] a);
    send(1, {`FSP_OP_WREN, 32'h0});
    send(4, {`FSP_OP_SECT_ERASE, a, 8'h00});
  endtask

  // Reset doubles as a power cycle
  task automatic do_reset();
    srst = 1'b1;
    repeat (12) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    pulses(0, 0, 0);
  endtask

  task automatic t_reset();
    check(status_word_o, 24'h600000);
    check({17'h0, drive_pct_o}, 24'h19);
    check({22'h0, hold_en_o, quad_io_en_o}, 24'h2);
    send(2, {`FSP_OP_RDSR3, 32'h0});
    check({16'h0, i_fsp_spi_host.rd_byte}, 24'h60);
    check({23'h0, miso_oe_n}, 24'h1);
  endtask

  task automatic t_gate();
    send(2, {`FSP_OP_WRSR1, 8'h80, 24'h0});
    pulses(1, 0, 0);
    send(1, {`FSP_OP_WREN, 32'h0});
    check(status_word_o, 24'h600002);
    wp_n_pin = 1'b0;
    send(2, {`FSP_OP_WRSR1, 8'h80, 24'h0});
    check(status_word_o, 24'h600080);
    wr(`FSP_OP_WRSR1, 8'h84);
    check(status_word_o, 24'h600082);
    pulses(1, 0, 0);
    wp_n_pin = 1'b1;
    send(2, {`FSP_OP_WRSR1, 8'h87, 24'h0});
    check(status_word_o, 24'h600084);
    wr(`FSP_OP_WRSR2, 8'h02);
    wp_n_pin = 1'b0;
    wr(`FSP_OP_WRSR1, 8'hC4);
    check(status_word_o, 24'h6002C4);
    check({22'h0, hold_en_o, quad_io_en_o}, 24'h1);
    pulses(0, 0, 0);
  endtask

  // Sector units, block units, bottom end, then complement
  task automatic t_range();
    erase(24'h3FF000);
    erase(24'h3FE000);
    pulses(0, 1, 1);
    check({2'b0, op_lo_o}, 24'h3FE000);
    check({2'b0, op_hi_o}, 24'h3FEFFF);
    wr(`FSP_OP_WRSR1, 8'h84);
    erase(24'h3F0000);
    erase(24'h3EF000);
    wr(`FSP_OP_WRSR1, 8'hA4);
    erase(24'h000000);
    pulses(0, 2, 1);
    wr(`FSP_OP_WRSR2, 8'h42);
    erase(24'h010000);
    erase(24'h00F000);
    pulses(0, 1, 1);
  endtask

  task automatic t_drive();
    for (int d = 0; d < 4; d++) begin
      wr(`FSP_OP_WRSR3, 8'(d << 5));
      check({17'h0, drive_pct_o}, {17'h0, pct[d]});
      check({22'h0, drive_strength_o}, 24'(d));
    end
    wr(`FSP_OP_WRSR3, 8'h64);
    check({16'h0, status_word_o[23:16]}, 24'h64);
    erase(24'h00F000);
    pulses(0, 1, 0);
  endtask

  task automatic t_flags();
    send(1, {`FSP_OP_SUSPEND, 32'h0});
    check({23'h0, status_word_o[15]}, 24'h1);
    send(1, {`FSP_OP_RESUME, 32'h0});
    check({23'h0, status_word_o[15]}, 24'h0);
    wr(`FSP_OP_WRSR2, 8'h0A);
    wr(`FSP_OP_WRSR2, 8'h02);
    check({16'h0, status_word_o[15:8]}, 24'h0A);
    check({21'h0, sec_reg_ro_o}, 24'h1);
    wr(`FSP_OP_WRSR2, 8'h0B);
    wr(`FSP_OP_WRSR1, 8'h00);
    check({16'h0, status_word_o[7:0]}, 24'hA6);
    pulses(1, 0, 0);
    do_reset();
    check(status_word_o, 24'h600000);
  endtask

  // Program span, disable latch, then the prefixed permanent lock
  task automatic t_ops();
    send(1, {`FSP_OP_WREN, 32'h0});
    send(5, {`FSP_OP_PROG, 24'h000123, 8'hA5});
    check(24'(n_prog), 24'h1);
    check({2'b0, op_lo_o}, 24'h000100);
    check({2'b0, op_hi_o}, 24'h0001FF);
    check({16'h0, status_word_o[7:0]}, 24'h00);
    send(1, {`FSP_OP_WREN, 32'h0});
    send(1, {`FSP_OP_WRDI, 32'h0});
    send(4, {`FSP_OP_SECT_ERASE, 24'h100000, 8'h00});
    pulses(0, 1, 0);
    send(1, {`FSP_OP_WREN, 32'h0});
    send(1, {`FSP_OP_PREFIX1, 32'h0});
    send(1, {`FSP_OP_PREFIX2, 32'h0});
    send(2, {`FSP_OP_WRSR2, 8'h01, 24'h0});
    check(status_word_o, 24'h600100);
    wr(`FSP_OP_WRSR1, 8'h04);
    check(status_word_o, 24'h600102);
    pulses(1, 0, 0);
  endtask

  task automatic stop_test();
    $display("checked %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected 8400 or so cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    stop_test();
  end

  initial begin
    srst = 1'b1;
    wp_n_pin = 1'b1;
    n_ref = 0;
    n_ign = 0;
    n_erase = 0;
    n_prog = 0;
    #1;
    do_reset();
    t_reset();
    t_gate();
    t_range();
    t_drive();
    t_flags();
    t_ops();
    stop_test();
  end
endmodule // fsp_status_protect_tb
